// *** pkg/xbc_pkg.sv ***
// package for the external memory bus cycle sequencer
// assumes one core clock; one input clock period (tcp) equals one core clock
package xbc_pkg;
    // bus cycle kinds requested by the core
    typedef enum logic [1:0] {
        XBC_FETCH = 2'h0,
        XBC_READ  = 2'h1,
        XBC_WRITE = 2'h2,
        XBC_PORT  = 2'h3
    } xbc_kind_type;

    // one request from the core side
    typedef struct packed {
        xbc_kind_type kind;
        logic [15:0] addr;
        logic [7:0] wdata;
    } xbc_req_type;

    // one answer towards the core side
    typedef struct packed {
        xbc_kind_type kind;
        logic [7:0] rdata;
    } xbc_rsp_type;

    // cycle counts, one tcp each
    localparam logic [3:0] XBC_ALE_HIGH_CYC = 4'h2;    // latch strobe high width
    localparam logic [3:0] XBC_ADDR_HOLD_CYC = 4'h1;   // address hold after latch fall
    localparam logic [3:0] XBC_FETCH_LOW_CYC = 4'h3;   // fetch strobe low width
    localparam logic [3:0] XBC_FETCH_CAP_CYC = 4'h2;   // data valid after fetch strobe low
    localparam logic [3:0] XBC_FETCH_GAP_CYC = 4'h1;   // float after fetch strobe high
    localparam logic [3:0] XBC_RW_DELAY_CYC = 4'h3;    // latch fall to read/write strobe
    localparam logic [3:0] XBC_RW_LOW_CYC = 4'h6;      // read/write strobe low width
    localparam logic [3:0] XBC_READ_CAP_CYC = 4'h4;    // data valid after read strobe low
    localparam logic [3:0] XBC_READ_GAP_CYC = 4'h2;    // float after read strobe high
    localparam logic [3:0] XBC_WR_HOLD_CYC = 4'h1;     // write data hold after strobe high
    localparam logic [3:0] XBC_PORT_SAMPLE_CYC = 4'h5; // state five phase two slot
    localparam logic [3:0] XBC_PORT_UPDATE_CYC = 4'h6; // state six phase two slot
    // reset values
    localparam logic [7:0] XBC_PORT_RST = 8'hff;
    localparam logic [15:0] XBC_ADDR_RST = 16'h0000;
endpackage

// *** hdl/xbc_skid.sv ***
// two-entry valid/ready buffer
// assumes both sides on core_clk_i with synchronous reset
module xbc_skid #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // filling side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    logic [WIDTH-1:0] mem_q [2];  // storage words
    logic [WIDTH-1:0] mem_d [2];
    logic rd_q, rd_d;             // read pointer
    logic wr_q, wr_d;             // write pointer
    logic [1:0] cnt_q, cnt_d;     // occupancy

    ////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        logic push;
        logic pop;
        push = 1'b0;
        pop = 1'b0;
        mem_d = mem_q;
        rd_d = rd_q;
        wr_d = wr_q;
        push = in_valid_i && (cnt_q != 2'h2);
        pop = out_ready_i && (cnt_q != 2'h0);
        if (push) begin
            mem_d[wr_q] = in_data_i;
            wr_d = ~wr_q;
        end
        if (pop) begin
            rd_d = ~rd_q;
        end
        cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    end

    // registers only
    always_ff @(posedge core_clk_i) begin
        mem_q <= mem_d;
        if (srst_i) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            rd_q <= rd_d;
            wr_q <= wr_d;
            cnt_q <= cnt_d;
        end
    end

    // full and empty straight from the count
    assign in_ready_o = (cnt_q != 2'h2);
    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o = mem_q[rd_q];
endmodule // xbc_skid

// *** hdl/xbc_sync.sv ***
// two-flop synchroniser for pin inputs
// assumes the pins are asynchronous to core_clk_i
module xbc_sync #(
    parameter int WIDTH = 8
) (
    // clock
    input wire logic core_clk_i,
    // raw pin and synchronised copy
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;  // first stage, read only by second
    logic [WIDTH-1:0] sync_q;  // second stage

    // plain shift, no reset needed for data
    always_ff @(posedge core_clk_i) begin
        meta_q <= pin_i;
        sync_q <= meta_q;
    end

    assign sync_o = sync_q;
endmodule // xbc_sync

// *** hdl/xbc_bus.sv ***
// multiplexed external memory bus cycle sequencer
// assumes the core clock is the input clock; a stopped clock just freezes state
module xbc_bus (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // core request side
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire xbc_pkg::xbc_req_type req_i,
    // core answer side
    output logic rsp_valid_o,
    input wire logic rsp_ready_i,
    output xbc_pkg::xbc_rsp_type rsp_o,
    // bus strobes, active low where named _n
    output logic ale_o,
    output logic program_fetch_strobe_n_o,
    output logic rd_n_o,
    output logic wr_n_o,
    // low address / data port, two-way
    input wire logic [7:0] ad_i,
    output logic [7:0] ad_o,
    output logic ad_oe_o,
    // high address port
    output logic [7:0] addr_hi_o,
    // general purpose port
    input wire logic [7:0] port_i,
    output logic [7:0] port_o
);
    // sequencer states, gray from XBC_IDLE to XBC_STROBE and on to XBC_HOLD
    typedef enum logic [2:0] {
        XBC_IDLE = 3'b000,
        XBC_ALE = 3'b001,
        XBC_SETUP = 3'b011,
        XBC_STROBE = 3'b010,
        XBC_HOLD = 3'b110,
        XBC_GAP = 3'b111,
        XBC_ANSWER = 3'b101
    } xbc_state_type;

    ////////////////////////////////////////////////////////////////
    // declarations
    xbc_state_type st_q, st_d;              // sequencer state
    logic [3:0] cnt_q, cnt_d;               // cycles within a state
    xbc_pkg::xbc_req_type cur_q, cur_d;     // request in flight
    logic [7:0] cap_q, cap_d;               // captured bus byte
    logic ale_q, ale_d;                     // latch strobe
    logic pfs_n_q, pfs_n_d;                 // fetch strobe, low active
    logic rd_n_q, rd_n_d;                   // read strobe
    logic wr_n_q, wr_n_d;                   // write strobe
    logic [7:0] ad_q, ad_d;                 // low port drive value
    logic ad_oe_q, ad_oe_d;                 // low port drive enable
    logic [7:0] hi_q, hi_d;                 // high address
    logic [7:0] port_q, port_d;             // port output latch
    logic [7:0] ad_s, port_s;               // synchronised pins
    logic ans_valid;                        // answer into buffer
    logic ans_ready;                        // buffer can take it
    xbc_pkg::xbc_rsp_type ans;              // answer word
    logic rsp_valid_w;                      // buffer out valid
    xbc_pkg::xbc_rsp_type rsp_w;            // buffer out data
    logic [7:0] ad_last;                    // value to capture with

    ////////////////////////////////////////////////////////////////
    // pin synchronisers; the pipe delay is absorbed by a late capture
    xbc_sync #(.WIDTH(8)) u_sync_ad (
        .core_clk_i(core_clk_i),
        .pin_i(ad_i),
        .sync_o(ad_s)
    );
    xbc_sync #(.WIDTH(8)) u_sync_port (
        .core_clk_i(core_clk_i),
        .pin_i(port_i),
        .sync_o(port_s)
    );

    // answer buffer so a stalled consumer loses no byte
    xbc_skid #(.WIDTH($bits(xbc_pkg::xbc_rsp_type))) u_skid (
        .core_clk_i(core_clk_i),
        .srst_i(srst_i),
        .in_valid_i(ans_valid),
        .in_ready_o(ans_ready),
        .in_data_i(ans),
        .out_valid_o(rsp_valid_w),
        .out_ready_i(rsp_ready_i),
        .out_data_o(rsp_w)
    );

    // the answer word and strobe come from registered state
    assign ad_last = ad_s;
    assign ans_valid = (st_q == XBC_ANSWER);
    assign ans = '{kind: cur_q.kind, rdata: cap_q};

    // count-done helper, used by every timed state
    function automatic logic done(input logic [3:0] cnt, input logic [3:0] lim);
        done = (cnt == lim - 4'h1);
    endfunction

    ////////////////////////////////////////////////////////////////
    // sequencer next-state logic
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q + 4'h1;
        cur_d = cur_q;
        cap_d = cap_q;
        ale_d = ale_q;
        pfs_n_d = pfs_n_q;
        rd_n_d = rd_n_q;
        wr_n_d = wr_n_q;
        ad_d = ad_q;
        ad_oe_d = ad_oe_q;
        hi_d = hi_q;
        port_d = port_q;
        case (st_q)
            XBC_IDLE: begin
                // idle: take a new request
                cnt_d = 4'h0;
                if (req_valid_i) begin
                    cur_d = req_i;
                    st_d = XBC_ALE;
                    ale_d = 1'b1;
                    ad_d = req_i.addr[7:0];
                    ad_oe_d = 1'b1;
                    hi_d = req_i.addr[15:8];
                end
            end
            XBC_ALE: begin
                // latch high two tcp, address already stable
                if (done(cnt_q, xbc_pkg::XBC_ALE_HIGH_CYC)) begin
                    ale_d = 1'b0;
                    cnt_d = 4'h0;
                    st_d = XBC_SETUP;
                end
            end
            XBC_SETUP: begin
                // address held one tcp past latch fall
                if (cnt_q == xbc_pkg::XBC_ADDR_HOLD_CYC - 4'h1) begin
                    if (cur_q.kind == xbc_pkg::XBC_WRITE) begin
                        ad_d = cur_q.wdata;
                    end else begin
                        ad_oe_d = 1'b0;
                    end
                end
                if (cur_q.kind == xbc_pkg::XBC_FETCH) begin
                    if (done(cnt_q, xbc_pkg::XBC_ADDR_HOLD_CYC)) begin
                        pfs_n_d = 1'b0;
                        cnt_d = 4'h0;
                        st_d = XBC_STROBE;
                    end
                end else if (done(cnt_q, xbc_pkg::XBC_RW_DELAY_CYC)) begin
                    cnt_d = 4'h0;
                    st_d = XBC_STROBE;
                    rd_n_d = ~(cur_q.kind == xbc_pkg::XBC_READ);
                    wr_n_d = ~(cur_q.kind == xbc_pkg::XBC_WRITE);
                end
            end
            XBC_STROBE: begin
                // strobe low; capture late enough to cover the sync pipe
                if (cur_q.kind == xbc_pkg::XBC_FETCH) begin
                    if (done(cnt_q, xbc_pkg::XBC_FETCH_LOW_CYC)) begin
                        pfs_n_d = 1'b1;
                        cnt_d = 4'h0;
                        st_d = XBC_GAP;
                    end
                end else begin
                    if (cur_q.kind == xbc_pkg::XBC_PORT) begin
                        if (cnt_q == xbc_pkg::XBC_PORT_SAMPLE_CYC - 4'h1) begin
                            cap_d = port_s;
                        end
                        if (cnt_q == xbc_pkg::XBC_PORT_UPDATE_CYC - 4'h1) begin
                            port_d = cur_q.wdata;
                        end
                    end
                    if (done(cnt_q, xbc_pkg::XBC_RW_LOW_CYC)) begin
                        if (cur_q.kind == xbc_pkg::XBC_READ) begin
                            cap_d = ad_last;
                        end
                        rd_n_d = 1'b1;
                        wr_n_d = 1'b1;
                        cnt_d = 4'h0;
                        st_d = (cur_q.kind == xbc_pkg::XBC_WRITE) ? XBC_HOLD : XBC_GAP;
                    end
                end
            end
            XBC_HOLD: begin
                // write data stays driven past the strobe
                if (done(cnt_q, xbc_pkg::XBC_WR_HOLD_CYC)) begin
                    ad_oe_d = 1'b0;
                    cnt_d = 4'h0;
                    st_d = XBC_ANSWER;
                end
            end
            XBC_GAP: begin
                // fetch byte: the first sync stage took it while the strobe was low,
                // so a memory answering at the last legal edge is still caught
                if (cur_q.kind == xbc_pkg::XBC_FETCH && cnt_q == 4'h0) begin
                    cap_d = ad_last;
                end
                // wait for the memory to float before the next address
                if ((cur_q.kind == xbc_pkg::XBC_FETCH
                        && done(cnt_q, xbc_pkg::XBC_FETCH_GAP_CYC))
                    || done(cnt_q, xbc_pkg::XBC_READ_GAP_CYC)) begin
                    cnt_d = 4'h0;
                    st_d = XBC_ANSWER;
                end
            end
            XBC_ANSWER: begin
                // hand the answer over; stall while the buffer is full
                cnt_d = 4'h0;
                if (ans_ready) begin
                    st_d = XBC_IDLE;
                end
            end
            default: begin
                st_d = XBC_IDLE;
                cnt_d = 4'h0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // sequencer registers; a halted clock simply freezes them
    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            st_q <= XBC_IDLE;
            cnt_q <= 4'h0;
            cur_q <= '0;
            cap_q <= 8'h00;
            ale_q <= 1'b0;
            pfs_n_q <= 1'b1;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            ad_q <= xbc_pkg::XBC_ADDR_RST[7:0];
            ad_oe_q <= 1'b0;
            hi_q <= xbc_pkg::XBC_ADDR_RST[15:8];
            port_q <= xbc_pkg::XBC_PORT_RST;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            cur_q <= cur_d;
            cap_q <= cap_d;
            ale_q <= ale_d;
            pfs_n_q <= pfs_n_d;
            rd_n_q <= rd_n_d;
            wr_n_q <= wr_n_d;
            ad_q <= ad_d;
            ad_oe_q <= ad_oe_d;
            hi_q <= hi_d;
            port_q <= port_d;
        end
    end

    ////////////////////////////////////////////////////////////////
    // bus and port outputs straight from flops; ready decoded from state, answer from the buffer
    assign req_ready_o = (st_q == XBC_IDLE);
    assign rsp_valid_o = rsp_valid_w;
    assign rsp_o = rsp_w;
    assign ale_o = ale_q;
    assign program_fetch_strobe_n_o = pfs_n_q;
    assign rd_n_o = rd_n_q;
    assign wr_n_o = wr_n_q;
    assign ad_o = ad_q;
    assign ad_oe_o = ad_oe_q;
    assign addr_hi_o = hi_q;
    assign port_o = port_q;
endmodule // xbc_bus

// *** dv/xbc_bus_monitor.sv ***
// checker for the bus sequencer's strobe and address timing
// assumes it is bound to xbc_bus and sees only its ports
module xbc_bus_monitor (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic srst_i,
    // bus outputs
    input wire logic ale_o,
    input wire logic program_fetch_strobe_n_o,
    input wire logic rd_n_o,
    input wire logic wr_n_o,
    input wire logic [7:0] ad_o,
    input wire logic ad_oe_o,
    input wire logic [7:0] addr_hi_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);
    ////////////////////////////////////////////////////////////////////////////////
    // latch pulse: two tcp high, then low
    sequence s_ale_pulse;
        ale_o [*2] ##1 !ale_o;
    endsequence
    // fetch strobe: three tcp low, then high
    sequence s_fetch_low;
        !program_fetch_strobe_n_o [*3] ##1 program_fetch_strobe_n_o;
    endsequence
    // read or write strobe: six tcp low, then high
    sequence s_rw_low(sig);
        !sig [*6] ##1 sig;
    endsequence
    property p_ale_width;
        $rose(ale_o) |-> s_ale_pulse;
    endproperty
    a_ale_width: assert property (p_ale_width) else $error("latch width wrong");
    // address driven a tcp before and after the latch fall
    property p_addr_hold;
        $fell(ale_o) |-> ad_oe_o && $stable(ad_o) && $stable(addr_hi_o) && $past(ad_oe_o, 2);
    endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address not held");
    property p_fetch_delay;
        $fell(program_fetch_strobe_n_o) |-> $past(ale_o, 2) && !$past(ale_o);
    endproperty
    a_fetch_delay: assert property (p_fetch_delay) else $error("fetch delay wrong");
    property p_fetch_width;
        $fell(program_fetch_strobe_n_o) |-> s_fetch_low;
    endproperty
    a_fetch_width: assert property (p_fetch_width) else $error("fetch width wrong");
    property p_rw_delay;
        ($fell(rd_n_o) || $fell(wr_n_o)) |-> $past(ale_o, 4) && !$past(ale_o, 3);
    endproperty
    a_rw_delay: assert property (p_rw_delay) else $error("strobe delay wrong");
    property p_rd_width;
        $fell(rd_n_o) |-> s_rw_low(rd_n_o);
    endproperty
    a_rd_width: assert property (p_rd_width) else $error("read width wrong");
    property p_wr_width;
        $fell(wr_n_o) |-> s_rw_low(wr_n_o);
    endproperty
    a_wr_width: assert property (p_wr_width) else $error("write width wrong");
    property p_wr_setup;
        $fell(wr_n_o) |-> ad_oe_o && $past(ad_oe_o) && $stable(ad_o);
    endproperty
    a_wr_setup: assert property (p_wr_setup) else $error("write data late");
    property p_wr_hold;
        $rose(wr_n_o) |-> ad_oe_o && $stable(ad_o);
    endproperty
    a_wr_hold: assert property (p_wr_hold) else $error("write data dropped");
    // high address frozen while any strobe is low
    property p_hi_stable;
        (!program_fetch_strobe_n_o || !rd_n_o || !wr_n_o) |-> $stable(addr_hi_o);
    endproperty
    a_hi_stable: assert property (p_hi_stable) else $error("high address moved");
    // the low port is left to the memory while it answers a fetch
    property p_fetch_quiet;
        !program_fetch_strobe_n_o |-> !ad_oe_o;
    endproperty
    a_fetch_quiet: assert property (p_fetch_quiet) else $error("bus driven in fetch");
endmodule // xbc_bus_monitor

bind xbc_bus xbc_bus_monitor u_mon (.core_clk_i(core_clk_i), .srst_i(srst_i), .ale_o(ale_o),
    .program_fetch_strobe_n_o(program_fetch_strobe_n_o), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o),
    .ad_o(ad_o), .ad_oe_o(ad_oe_o), .addr_hi_o(addr_hi_o));

// *** dv/xbc_mem_model.sv ***
// behavioural program and data memory with address latch, far side of the bus
// assumes strobes come from xbc_bus on the same clock
module xbc_mem_model (
    // clock and pacing
    input wire logic core_clk_i,
    input wire logic slow_i,
    // strobes
    input wire logic ale_i,
    input wire logic fetch_n_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    // master side of the low port, high address
    input wire logic [7:0] dev_ad_i,
    input wire logic dev_oe_i,
    input wire logic [7:0] hi_i,
    // resolved level of the low port
    output logic [7:0] bus_o
);
    logic [7:0] mem [logic [15:0]]; // written bytes; others read a pattern
    logic [15:0] lat_q = 16'h0000; // address latch
    logic [7:0] data_q = 8'h00;
    logic [7:0] last_q = 8'h00;
    int low_cnt = 0;
    int hold_cnt = 0;
    logic wr_was_q = 1'b1;
    logic strobe_low;
    logic mem_drive;
    assign strobe_low = !fetch_n_i || !rd_n_i;
    // a slow memory answers at the last legal edge: two tcp for fetch, four for read
    assign mem_drive = (strobe_low && low_cnt >= (slow_i ? (fetch_n_i ? 3 : 1) : 0))
        || hold_cnt != 0;
    // released lines wander instead of keeping the old byte
    assign bus_o = dev_oe_i ? dev_ad_i : (mem_drive ? data_q : ~last_q);
    ////////////////////////////////////////////////////////////////////////////////
    // latch, lookup, hold and store
    always @(posedge core_clk_i) begin
        last_q <= bus_o;
        if (ale_i) lat_q <= {hi_i, dev_ad_i};
        data_q <= mem.exists(lat_q) ? mem[lat_q] : (lat_q[7:0] ^ lat_q[15:8] ^ 8'h3c);
        low_cnt <= strobe_low ? low_cnt + 1 : 0;
        // byte kept one tcp after a fetch, two after a read
        if (strobe_low) hold_cnt <= fetch_n_i ? 2 : 1;
        else if (hold_cnt != 0) hold_cnt <= hold_cnt - 1;
        wr_was_q <= wr_n_i;
        if (wr_n_i && !wr_was_q) mem[lat_q] = bus_o;
    end
endmodule // xbc_mem_model

// *** dv/xbc_bus_bench.sv ***
// self-checking bench for the external bus sequencer
// assumes xbc_bus, its buffer and synchroniser, the memory model and checker
`define XBC_CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin \
    err_total++; $display("[FAIL] %s expected %h seen %h", what, exp, got); end end
module xbc_bus_bench;
    timeunit 1ns;
    timeprecision 1ps;
    // one expected answer
    typedef struct packed {
        xbc_pkg::xbc_kind_type kind;
        logic [7:0] rdata;
        logic [7:0] wdata;
    } xbc_exp_type;
    logic core_clk_i = 1'b0;
    logic clk_run = 1'b1; // low halts the clock at its present level
    logic srst_i = 1'b1;
    logic req_valid_i = 1'b0;
    logic req_ready_o, rsp_valid_o, ale_o, fetch_n, rd_n_o, wr_n_o, ad_oe_o;
    xbc_pkg::xbc_req_type req_i = '0;
    logic rsp_ready_i = 1'b1;
    xbc_pkg::xbc_rsp_type rsp_o;
    logic [7:0] ad_o, ad_i, addr_hi_o, port_o;
    logic [7:0] port_i = 8'h00;
    logic mem_slow = 1'b0;
    logic stall_rand = 1'b0;
    logic [7:0] shadow [logic [15:0]]; // bench's own view of written bytes
    xbc_exp_type exp_q [$];
    xbc_exp_type got_e;
    int err_total = 0;
    int samples_checked = 0;
    int seed = 60;

    always #20 if (clk_run) core_clk_i = ~core_clk_i;

    xbc_bus dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o), .req_i(req_i), .rsp_valid_o(rsp_valid_o),
        .rsp_ready_i(rsp_ready_i), .rsp_o(rsp_o), .ale_o(ale_o),
        .program_fetch_strobe_n_o(fetch_n), .rd_n_o(rd_n_o), .wr_n_o(wr_n_o), .ad_i(ad_i),
        .ad_o(ad_o), .ad_oe_o(ad_oe_o), .addr_hi_o(addr_hi_o), .port_i(port_i),
        .port_o(port_o));
    xbc_mem_model u_mem (.core_clk_i(core_clk_i), .slow_i(mem_slow), .ale_i(ale_o),
        .fetch_n_i(fetch_n), .rd_n_i(rd_n_o), .wr_n_i(wr_n_o), .dev_ad_i(ad_o),
        .dev_oe_i(ad_oe_o), .hi_i(addr_hi_o), .bus_o(ad_i));
    ////////////////////////////////////////////////////////////////////////////////
    // one request; notes the expected answer once taken
    task automatic do_req(input xbc_pkg::xbc_kind_type k, input logic [15:0] a,
        input logic [7:0] w);
        xbc_exp_type e;
        int n;
        @(negedge core_clk_i);
        req_i = '{kind: k, addr: a, wdata: w};
        mem_slow = 1'($random(seed));
        req_valid_i = 1'b1;
        n = 0;
        do begin @(posedge core_clk_i); n++; end while (req_ready_o !== 1'b1 && n < 400);
        `XBC_CHK("request taken", 1'b1, req_ready_o)
        @(negedge core_clk_i);
        req_valid_i = 1'b0;
        // port pins move only after the previous port access sampled them
        if (k == xbc_pkg::XBC_PORT) port_i = 8'($random(seed));
        e.kind = k;
        e.wdata = w;
        e.rdata = (k == xbc_pkg::XBC_PORT) ? port_i :
            (shadow.exists(a) ? shadow[a] : (a[7:0] ^ a[15:8] ^ 8'h3c));
        if (k == xbc_pkg::XBC_WRITE) shadow[a] = w;
        exp_q.push_back(e);
    endtask
    // reset for three edges; latch and fetch strobe must sit at their idle levels, ready high
    task automatic reset_pulse;
        srst_i = 1'b1;
        repeat (3) @(posedge core_clk_i);
        `XBC_CHK("reset latch", 1'b0, ale_o)
        `XBC_CHK("reset fetch strobe", 1'b1, fetch_n)
        `XBC_CHK("reset ready", 1'b1, req_ready_o)
        @(negedge core_clk_i);
        srst_i = 1'b0;
    endtask
    // wait until every noted answer came back
    task automatic drain;
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 2000) begin @(posedge core_clk_i); n++; end
        `XBC_CHK("answers left", 0, exp_q.size())
        @(negedge core_clk_i);
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // answer watcher: oldest note against each accepted answer
    always @(posedge core_clk_i) begin
        if (!srst_i && rsp_valid_o === 1'b1 && rsp_ready_i === 1'b1) begin
            got_e = exp_q.pop_front();
            `XBC_CHK("kind", got_e.kind, rsp_o.kind)
            if (got_e.kind == xbc_pkg::XBC_FETCH) `XBC_CHK("fetch", got_e.rdata, rsp_o.rdata)
            if (got_e.kind == xbc_pkg::XBC_READ) `XBC_CHK("read", got_e.rdata, rsp_o.rdata)
            if (got_e.kind == xbc_pkg::XBC_PORT) `XBC_CHK("port in", got_e.rdata, rsp_o.rdata)
            if (got_e.kind == xbc_pkg::XBC_PORT) `XBC_CHK("port out", got_e.wdata, port_o)
        end
    end
    // random answer stalls, mostly ready
    always @(negedge core_clk_i) if (stall_rand) rsp_ready_i <= ($random(seed) & 3) != 0;
    initial begin
        #400us;
        err_total++;
        $display("[FAIL] run expected done seen hang");
        tally_and_finish;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        reset_pulse();
        // every kind at both address ends, then read back
        for (int k = 0; k < 4; k++) begin
            do_req(xbc_pkg::xbc_kind_type'(k), 16'h0000, 8'ha5);
            do_req(xbc_pkg::xbc_kind_type'(k), 16'hffff, 8'h5a);
        end
        do_req(xbc_pkg::XBC_READ, 16'h0000, 8'h00);
        do_req(xbc_pkg::XBC_FETCH, 16'hffff, 8'h00);
        drain();
        // answers pile up while the receiver stalls; none may be lost
        rsp_ready_i = 1'b0;
        repeat (3) do_req(xbc_pkg::XBC_READ, 16'($random(seed)), 8'h00);
        repeat (40) @(posedge core_clk_i);
        `XBC_CHK("buffer full valid", 1'b1, rsp_valid_o)
        `XBC_CHK("buffer full ready", 1'b0, req_ready_o)
        @(negedge core_clk_i);
        rsp_ready_i = 1'b1;
        drain();
        // clock halted high, then low, in mid-cycle
        fork
            do_req(xbc_pkg::XBC_READ, 16'h1234, 8'h00);
            begin
                repeat (8) @(posedge core_clk_i);
                #5 clk_run = 1'b0;
                #1000 clk_run = 1'b1;
                repeat (3) @(negedge core_clk_i);
                #5 clk_run = 1'b0;
                #1000 clk_run = 1'b1;
            end
        join
        drain();
        // second reset in mid-run, then traffic again from idle
        reset_pulse();
        // random traffic, random memory pacing, random stalls
        stall_rand = 1'b1;
        repeat (40) do_req(xbc_pkg::xbc_kind_type'(2'($random(seed))), 16'($random(seed)),
            8'($random(seed)));
        stall_rand = 1'b0;
        @(negedge core_clk_i);
        rsp_ready_i = 1'b1;
        drain();
        tally_and_finish;
    end
endmodule // xbc_bus_bench
